// file: logic/txsw_defines.svh
`ifndef TXSW_DEFINES_SVH
`define TXSW_DEFINES_SVH
// status word bit positions
`define TXSW_DEFER_BIT      0
`define TXSW_UNDERRUN_BIT   1
`define TXSW_XLATE_BIT      2
`define TXSW_COLL_LSB       3
`define TXSW_COLL_MSB       6
`define TXSW_HBEAT_BIT      7
`define TXSW_EXCESS_BIT     8
`define TXSW_LATE_BIT       9
`define TXSW_NOCARR_BIT     10
`define TXSW_LOST_BIT       11
`define TXSW_LENGTH_BIT     12
`define TXSW_UNDEF_LOW_BIT  13
`define TXSW_WDOG_BIT       14
`define TXSW_SUMMARY_BIT    15
`define TXSW_REFL_LSB       16
`define TXSW_REFL_MSB       29
`define TXSW_UNDEF_HIGH_BIT 30
`define TXSW_OWNER_BIT      31
`define TXSW_MAX_COLL       5'h10
`define TXSW_LOOPBACK       2'h1
// control register resume strobe
`define TXSW_RESUME_BIT     8
// register byte offsets
`define TXSW_A_STATUS  4'h0
`define TXSW_A_MASK    4'h4
`define TXSW_A_CTRL    4'h8
`define TXSW_A_WORD    4'hc
// interrupt status bits
`define TXSW_I_DONE    0
`define TXSW_I_TXINT   1
`define TXSW_I_WDOG    2
`define TXSW_I_WORD    3
`endif

// file: logic/txsw_pkg.sv
package txsw_pkg;
   typedef enum logic [1:0] {TXSW_RUN, TXSW_SUSP, TXSW_STOP} txsw_proc_t;
endpackage

// file: logic/txsw_writeback.sv
`timescale 1ns/1ps
`include "txsw_defines.svh"
//////////////////////////////////////////////////////////////////////////////
module txsw_writeback
   import txsw_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   // frame events from the transmitter and descriptor flags
   input  wire logic        frameStart,
   input  wire logic        chanBusy,
   input  wire logic        fifoEmpty,
   input  wire logic        xlateFail,
   input  wire logic        virtual_addressing_flag,
   input  wire logic        collision,
   input  wire logic        lateCollision,
   input  wire logic        heartbeatSeen,
   input  wire logic        carrierSense,
   input  wire logic        chainFault,
   input  wire logic        watchdogExpire,
   input  wire logic [13:0] bitTimeCount,
   input  wire logic        frameDone,
   input  wire logic        last_segment_flag,
   input  wire logic        interrupt_on_completion_flag,
   // status word write-back port, abort and interrupt request
   output logic             wbValid,
   output logic [31:0]      tx_status_word,
   output logic             txAbort,
   output logic             intReq,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);
   //////////////////////////////////////////////////////////////////////////
   txsw_proc_t  procState;
   logic        inFrame;
   logic        deferred, underflow, xlate, excess, late, noCarrier, lost;
   logic        lenErr, timeout, hbFail, carrierSeen;
   logic [4:0]  collCount;
   logic [13:0] reflCount;
   logic [3:0]  intStatus;
   logic [3:0]  intMask;
   logic [1:0]  operating_mode_field;
   logic        resume;
   logic        abortNow, frameEnd, suspendErr;
   logic [31:0] next_word;
   logic        dpWrite;
   logic [3:0]  dpAddr;
   logic [3:0]  next_intStatus;
   logic        w1cHit;

   function automatic logic isErr(input logic [31:0] w);
      isErr = w[`TXSW_UNDERRUN_BIT] | w[`TXSW_XLATE_BIT] | w[`TXSW_EXCESS_BIT] |
              w[`TXSW_LATE_BIT] | w[`TXSW_NOCARR_BIT] | w[`TXSW_LOST_BIT] |
              w[`TXSW_LENGTH_BIT] | w[`TXSW_WDOG_BIT];
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // abort on excessive collisions, late collision, watchdog, or halting errors
   assign abortNow   = inFrame & ((collision & (collCount == `TXSW_MAX_COLL - 5'h01)) |
                       lateCollision | watchdogExpire | fifoEmpty |
                       (xlateFail & virtual_addressing_flag) | chainFault);
   assign frameEnd   = inFrame & (frameDone | abortNow);
   assign suspendErr = inFrame & (fifoEmpty | (xlateFail & virtual_addressing_flag) | chainFault);
   assign txAbort    = abortNow;

   // frame tracking
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         inFrame <= 1'b0;
      end else if (clkEn) begin
         if (frameEnd) begin
            inFrame <= 1'b0;
         end else if (frameStart && procState == TXSW_RUN) begin
            inFrame <= 1'b1;
         end
      end
   end

   // per-frame condition capture
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         deferred    <= 1'b0;
         underflow   <= 1'b0;
         xlate       <= 1'b0;
         excess      <= 1'b0;
         late        <= 1'b0;
         lost        <= 1'b0;
         carrierSeen <= 1'b0;
         lenErr      <= 1'b0;
         timeout     <= 1'b0;
         hbFail      <= 1'b0;
         collCount   <= 5'h00;
         reflCount   <= 14'h0000;
      end else if (clkEn) begin
         if (frameStart && !inFrame && procState == TXSW_RUN) begin
            deferred    <= chanBusy;
            underflow   <= 1'b0;
            xlate       <= 1'b0;
            excess      <= 1'b0;
            late        <= 1'b0;
            lost        <= 1'b0;
            carrierSeen <= carrierSense;
            lenErr      <= 1'b0;
            timeout     <= 1'b0;
            hbFail      <= 1'b0;
            collCount   <= 5'h00;
            reflCount   <= 14'h0000;
         end else if (inFrame) begin
            if (fifoEmpty) underflow <= 1'b1;
            if (xlateFail && virtual_addressing_flag) xlate <= 1'b1;
            if (collision && collCount != `TXSW_MAX_COLL) collCount <= collCount + 5'h01;
            if (collision && collCount == `TXSW_MAX_COLL - 5'h01) begin
               excess <= 1'b1;
               reflCount <= bitTimeCount;
            end
            if (lateCollision) late <= 1'b1;
            if (carrierSense) carrierSeen <= 1'b1;
            if (carrierSeen && !carrierSense) lost <= 1'b1;
            if (chainFault) lenErr <= 1'b1;
            if (watchdogExpire) timeout <= 1'b1;
            if (frameDone) hbFail <= ~heartbeatSeen;
         end
      end
   end

   assign noCarrier = ~(carrierSeen | carrierSense);

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_word = 32'h0000_0000;
      next_word[`TXSW_DEFER_BIT]    = deferred;
      next_word[`TXSW_UNDERRUN_BIT] = underflow | (inFrame & fifoEmpty);
      next_word[`TXSW_XLATE_BIT]    = xlate | (inFrame & xlateFail & virtual_addressing_flag);
      next_word[`TXSW_COLL_MSB:`TXSW_COLL_LSB] = collCount[3:0] + {3'h0, collision};
      next_word[`TXSW_HBEAT_BIT]    = hbFail | (frameDone & ~heartbeatSeen);
      next_word[`TXSW_EXCESS_BIT]   = excess |
                                      (collision & (collCount == `TXSW_MAX_COLL - 5'h01));
      next_word[`TXSW_LATE_BIT]     = late | lateCollision;
      next_word[`TXSW_NOCARR_BIT]   = noCarrier & (operating_mode_field != `TXSW_LOOPBACK);
      next_word[`TXSW_LOST_BIT]     = (lost | (carrierSeen & ~carrierSense)) &
                                      (operating_mode_field != `TXSW_LOOPBACK);
      next_word[`TXSW_LENGTH_BIT]   = lenErr | chainFault;
      next_word[`TXSW_WDOG_BIT]     = timeout | watchdogExpire;
      next_word[`TXSW_SUMMARY_BIT]  = isErr(next_word);
      next_word[`TXSW_REFL_MSB:`TXSW_REFL_LSB] = next_word[`TXSW_EXCESS_BIT] ?
                                      (excess ? reflCount : bitTimeCount) : 14'h0000;
      // ownership handed back; bits 13 and 30 left zero
      next_word[`TXSW_OWNER_BIT]    = 1'b0;
   end

   // status word write-back
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wbValid        <= 1'b0;
         tx_status_word <= 32'h0000_0000;
      end else if (clkEn) begin
         wbValid <= frameEnd;
         if (frameEnd) tx_status_word <= next_word;
      end
   end

   // transmit process state
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         procState <= TXSW_RUN;
      end else if (clkEn) begin
         case (procState)
            TXSW_RUN: begin
               if (inFrame && watchdogExpire) procState <= TXSW_STOP;
               else if (suspendErr) procState <= TXSW_SUSP;
            end
            TXSW_SUSP, TXSW_STOP: begin
               if (resume) procState <= TXSW_RUN;
            end
            default: procState <= TXSW_RUN;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign w1cHit    = dpWrite && dpAddr == `TXSW_A_STATUS;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dpWrite <= 1'b0;
         dpAddr  <= 4'h0;
      end else if (clkEn && hready) begin
         dpWrite <= hsel & htrans[1] & hwrite;
         dpAddr  <= haddr[3:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         intMask              <= 4'h0;
         operating_mode_field <= 2'h0;
         resume               <= 1'b0;
      end else if (clkEn) begin
         resume <= 1'b0;
         if (dpWrite && dpAddr == `TXSW_A_MASK) intMask <= hwdata[3:0];
         if (dpWrite && dpAddr == `TXSW_A_CTRL) begin
            operating_mode_field <= hwdata[1:0];
            resume               <= hwdata[`TXSW_RESUME_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
      end else if (clkEn && hready) begin
         hrdata <= 32'h0000_0000;
         if (hsel && htrans[1] && !hwrite) begin
            case (haddr[3:0])
               `TXSW_A_STATUS: hrdata <= {28'h0, intStatus};
               `TXSW_A_MASK:   hrdata <= {28'h0, intMask};
               `TXSW_A_CTRL:   hrdata <= {22'h0, procState, 6'h0, operating_mode_field};
               `TXSW_A_WORD:   hrdata <= tx_status_word;
               default:        hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // sticky interrupt status, set wins over write-one clear
   always_comb begin
      next_intStatus = intStatus;
      if (w1cHit) next_intStatus = intStatus & ~hwdata[3:0];
      // complete and interrupt on halting error
      if (suspendErr) begin
         next_intStatus[`TXSW_I_DONE]  = 1'b1;
         next_intStatus[`TXSW_I_TXINT] = 1'b1;
      end
      if (inFrame && frameDone && last_segment_flag && interrupt_on_completion_flag)
         next_intStatus[`TXSW_I_TXINT] = 1'b1;
      if (inFrame && watchdogExpire) next_intStatus[`TXSW_I_WDOG] = 1'b1;
      if (frameEnd) next_intStatus[`TXSW_I_WORD] = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         intStatus <= 4'h0;
      end else if (clkEn) begin
         intStatus <= next_intStatus;
      end
   end

   assign intReq = |(intStatus & intMask);

   //////////////////////////////////////////////////////////////////////////
   a_summary_or: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wbValid |-> tx_status_word[`TXSW_SUMMARY_BIT] == isErr(tx_status_word))
      else $error("error summary mismatch");
   a_owner_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wbValid |-> !tx_status_word[`TXSW_OWNER_BIT])
      else $error("ownership not returned");
   a_undef_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wbValid |-> !tx_status_word[`TXSW_UNDEF_LOW_BIT] && !tx_status_word[`TXSW_UNDEF_HIGH_BIT])
      else $error("undefined bit set");
   a_underrun_suspend: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && inFrame && fifoEmpty && !watchdogExpire && procState == TXSW_RUN
      |=> procState == TXSW_SUSP && intStatus[`TXSW_I_TXINT])
      else $error("underflow did not suspend");
   a_wdog_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && inFrame && watchdogExpire
      |=> procState == TXSW_STOP && intStatus[`TXSW_I_WDOG] && tx_status_word[`TXSW_WDOG_BIT])
      else $error("watchdog did not stop");
   a_xlate_needs_virt: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && frameStart && !inFrame && procState == TXSW_RUN
      ##1 (!virtual_addressing_flag)[*2]
      |-> !xlate)
      else $error("translation bit without virtual addressing");
   a_excess_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && inFrame && collision && collCount == `TXSW_MAX_COLL - 5'h01
      |-> txAbort ##1 tx_status_word[`TXSW_EXCESS_BIT])
      else $error("no abort at sixteenth collision");
   a_late_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && inFrame && lateCollision
      |-> txAbort ##1 (wbValid && tx_status_word[`TXSW_LATE_BIT]))
      else $error("late collision not reported");
   a_loop_nc: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wbValid && $past(operating_mode_field) == `TXSW_LOOPBACK
      |-> !tx_status_word[`TXSW_NOCARR_BIT])
      else $error("no carrier in loopback");
   a_defer_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && frameStart && !inFrame && procState == TXSW_RUN
      |=> deferred == $past(chanBusy))
      else $error("deferral not captured");
   a_length_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && inFrame && chainFault
      |-> txAbort ##1 (wbValid && tx_status_word[`TXSW_LENGTH_BIT]))
      else $error("length error not reported");
   a_done_interrupt: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && inFrame && frameDone && last_segment_flag && interrupt_on_completion_flag
      |=> intStatus[`TXSW_I_TXINT])
      else $error("completion interrupt missing");
   a_refl_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clkEn && inFrame && collision && collCount == `TXSW_MAX_COLL - 5'h01
      |=> tx_status_word[`TXSW_REFL_MSB:`TXSW_REFL_LSB] == $past(bitTimeCount))
      else $error("reflectometer count lost");
endmodule

// file: sim/txsw_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module txsw_host_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        load,
   input  wire logic [2:0]  descIn,
   input  wire logic        wbValid,
   input  wire logic [31:0] tx_status_word,
   output logic [2:0]       descOut,
   output int               handBack
);
   logic owned;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         owned <= 1'b0;
         descOut <= 3'h0;
         handBack <= 0;
      end else if (load && !owned) begin
         descOut <= descIn;
         owned <= 1'b1;
      end else if (wbValid && !tx_status_word[31]) begin
         owned <= 1'b0;
         handBack <= handBack + 1;
      end
   end
endmodule

// file: sim/tx_descriptor_status_writeback_tb.sv
`timescale 1ns/1ps
module tx_descriptor_status_writeback_tb;
   logic        clk_sys = 0, rst_b = 0, clkEn = 1, frameStart = 0, chanBusy = 0;
   logic        fifoEmpty = 0, xlateFail = 0, collision = 0, lateCollision = 0;
   logic        heartbeatSeen = 1, carrierSense = 0, chainFault = 0, watchdogExpire = 0;
   logic        frameDone = 0, load = 0, hsel = 0, hwrite = 0, lb = 0;
   logic [13:0] bitTimeCount = 0;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2, descIn = 0, descOut;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, tx_status_word, lastW, lastC, r, mw, me;
   logic        wbValid, txAbort, intReq, hreadyout;
   logic [31:0] expQ[$], careQ[$];
   int          err_count = 0, n_tests = 0, abortCnt = 0, expAbort = 0, nFrames = 0;
   int          handBack;
   int          seed = 32'h4f010730;

   always #12.5 clk_sys = ~clk_sys;

   txsw_writeback txsw_writeback_inst (
      .clk_sys, .rst_b, .clkEn, .frameStart, .chanBusy, .fifoEmpty, .xlateFail,
      .virtual_addressing_flag(descOut[2]), .collision, .lateCollision, .heartbeatSeen,
      .carrierSense, .chainFault, .watchdogExpire, .bitTimeCount, .frameDone,
      .last_segment_flag(descOut[1]), .interrupt_on_completion_flag(descOut[0]),
      .wbValid, .tx_status_word, .txAbort, .intReq, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp()
   );
   txsw_host_model txsw_host_model_inst (
      .clk_sys, .rst_b, .load, .descIn, .wbValid, .tx_status_word, .descOut, .handBack
   );
////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, d);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic rdchk(input string name, input logic [31:0] a, m, e);
      ahb(0, a, 0);
      check(name, r & m, e);
   endtask

   // kind: 0 done, 1 underflow, 2 translation, 3 chain fault, 4 late, 6 watchdog
   task automatic frame(input int kind, n, cm, input logic busy, hb, virt, irqOnDone);
      logic [31:0] w, c;
      logic        ab;
      logic [13:0] t;
      t = $random(seed);
      ab = kind inside {1, 3, 4, 6} || (kind == 2 && virt) || n > 15;
      w = 0;
      w[0] = busy;
      w[1] = kind == 1;
      w[2] = kind == 2 && virt;
      w[6:3] = n[3:0];
      w[7] = !hb;
      w[8] = n > 15;
      w[9] = kind == 4;
      w[10] = cm == 1 && !lb;
      w[11] = cm == 2 && !lb;
      w[12] = kind == 3;
      w[14] = kind == 6;
      w[15] = |{w[12:8], w[14], w[2:1]};
      w[29:16] = t;
      c = ab ? 32'hffffff7f : 32'hffffffff;
      c = n > 15 ? c & 32'hffffff87 : c & 32'hc000ffff;
      lastW = w & c;
      lastC = c;
      expQ.push_back(w & c);
      careQ.push_back(c);
      expAbort += ab;
      nFrames++;
      load <= 1;
      descIn <= {virt, 1'b1, irqOnDone};
      @(posedge clk_sys);
      load <= 0;
      frameStart <= 1;
      chanBusy <= busy;
      carrierSense <= cm != 1;
      heartbeatSeen <= hb;
      bitTimeCount <= t;
      @(posedge clk_sys);
      frameStart <= 0;
      @(posedge clk_sys);
      if (n > 0) begin
         collision <= 1;
         repeat (n) @(posedge clk_sys);
         collision <= 0;
      end
      if (cm == 2) begin
         carrierSense <= 0;
         @(posedge clk_sys);
      end
      if (n < 16) begin
         fifoEmpty <= kind == 1;
         xlateFail <= kind == 2;
         chainFault <= kind == 3;
         lateCollision <= kind == 4;
         watchdogExpire <= kind == 6;
         frameDone <= kind == 0;
         @(posedge clk_sys);
         {fifoEmpty, xlateFail, chainFault, lateCollision, watchdogExpire} <= 5'h0;
         frameDone <= kind == 2 && !virt;
         @(posedge clk_sys);
         frameDone <= 0;
      end
      repeat (3) @(posedge clk_sys);
   endtask
////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      if (txAbort === 1'b1) abortCnt++;
      if (wbValid === 1'b1 && expQ.size() == 0) check("stray write-back", 1, 0);
      else if (wbValid === 1'b1) begin
         mw = tx_status_word & careQ.pop_front();
         me = expQ.pop_front();
         check("low flags", mw[7:0], me[7:0]);
         check("error flags", mw[15:8], me[15:8]);
         check("upper word", mw[31:16], me[31:16]);
      end
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1;
      @(posedge clk_sys);
      for (int i = 0; i < 5; i++) rdchk("reset value", i * 4, 32'hffffffff, 0);
      ahb(1, 4, 32'hf);
      frame(0, 1, 0, 1, 1, 0, 1);
      rdchk("tx interrupt", 0, 32'h2, 32'h2);
      check("irq level", intReq, 1);
      ahb(1, 4, 0);
      ahb(1, 0, 32'hf);
      frame(0, 0, 0, 0, 1, 0, 0);
      rdchk("no interrupt", 0, 32'h2, 0);
      frame(0, 0, 0, 0, 1, 0, 1);
      check("masked irq", intReq, 0);
      ahb(1, 4, 32'h2);
      @(posedge clk_sys);
      check("unmasked irq", intReq, 1);
      ahb(1, 0, 32'hf);
      @(posedge clk_sys);
      check("cleared irq", intReq, 0);
      for (int m = 0; m < 6; m++) begin
         lb = m[0];
         ahb(1, 8, {31'h0, lb});
         frame(0, 0, m / 2, 0, 1, 0, 0);
      end
      lb = 0;
      ahb(1, 8, 0);
      frame(0, 2, 0, 0, 0, 0, 0);
      frame(0, 15, 0, 1, 1, 0, 0);
      frame(0, 16, 0, 0, 1, 0, 0);
      frame(4, 3, 0, 0, 1, 0, 0);
      frame(2, 0, 0, 0, 1, 0, 0);
      for (int k = 1; k < 4; k++) begin
         ahb(1, 0, 32'hf);
         frame(k, 1, 0, 0, 1, 1, 0);
         rdchk("halt flags", 0, 32'h3, 32'h3);
         rdchk("suspended", 8, 32'h300, 32'h100);
         frameStart <= 1;
         @(posedge clk_sys);
         frameStart <= 0;
         repeat (4) @(posedge clk_sys);
         ahb(1, 8, 32'h100);
         // resume strobe takes one more edge to reach the process state
         @(posedge clk_sys);
         rdchk("resumed", 8, 32'h300, 0);
      end
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         frame(0, r[3:0], r[5:4] % 3, r[6], r[7], 0, r[8]);
      end
      rdchk("last word", 12, lastC, lastW);
      frame(6, 2, 0, 0, 1, 0, 0);
      rdchk("watchdog", 0, 32'h4, 32'h4);
      rdchk("stopped", 8, 32'h300, 32'h200);
      check("aborts", abortCnt, expAbort);
      check("hand back", handBack, nFrames);
      print_verdict();
   end

   initial begin
      #500000;
      err_count++;
      print_verdict();
   end
endmodule
